// File: rtl/lbs_apb_regs.sv
// apb slave holding the sequencer configuration registers
`timescale 1ns/1ps
`include "lbs_regs.svh"
module lbs_apb_regs
  import lbs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  lbs_cfg_if.regs          cfg
);
  lbs_reg_t r;
  lbs_reg_t next_r;

  // ----------------------------------------------------------------
  // decode: {hit, read data}; also used to validate writes
  // ----------------------------------------------------------------
  function automatic logic [8:0] regRead(input logic [11:0] a, input lbs_reg_t q, input logic [7:0] act);
    logic [7:0] idx;
    idx = a[`LBS_IDX_HI:`LBS_IDX_LO];
    regRead = 9'h000;
    if (a[`LBS_ADDR_TOP:`LBS_IDX_HI+1] != '0) regRead = 9'h000;
    else if (idx == `LBS_IDX_STAT) regRead = {1'b1, act};
    else if (idx == `LBS_IDX_POL) regRead = {1'b1, q.pol};
    else if (idx == `LBS_IDX_DRV) regRead = {1'b1, q.drv};
    else if (idx == `LBS_IDX_LINK) regRead = {1'b1, q.link};
    else if (idx == `LBS_IDX_BEH1) regRead = {1'b1, q.beh[7:0]};
    else if (idx == `LBS_IDX_BEH2) regRead = {1'b1, q.beh[15:8]};
    else if (idx == `LBS_IDX_P1PER) regRead = {1'b1, q.p1Per};
    else if (idx == `LBS_IDX_P2PER) regRead = {2'b10, q.p2Per};
    else if (idx == `LBS_IDX_BRPER) regRead = {2'b10, q.brPer};
    else if (idx == `LBS_IDX_CFG) regRead = {2'b10, q.cfg};
    else if (idx >= `LBS_IDX_DUTY0 && idx <= `LBS_IDX_DUTY3)
      regRead = {1'b1, q.duty[8*(idx[1:0]) +: 8]};
  endfunction : regRead

  // ----------------------------------------------------------------
  // one access per transfer, answered in the second access cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [8:0] rd;
    logic [7:0] idx;
    logic [7:0] wb;
    rd = regRead(paddr, r, cfg.active);
    idx = paddr[`LBS_IDX_HI:`LBS_IDX_LO];
    wb = pwdata[7:0];
    next_r = r;
    next_r.pready = 1'b0;
    if (psel && penable && !r.pready)
    begin
      next_r.pready = 1'b1;
      next_r.pslverr = ~rd[8];
      next_r.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd[7:0]};
      if (pwrite && rd[8])
      begin
        // status index ignores writes; reserved top bits dropped
        if (idx == `LBS_IDX_POL) next_r.pol = wb;
        else if (idx == `LBS_IDX_DRV) next_r.drv = wb;
        else if (idx == `LBS_IDX_LINK) next_r.link = wb;
        else if (idx == `LBS_IDX_BEH1) next_r.beh[7:0] = wb;   // [R1] [R2]
        else if (idx == `LBS_IDX_BEH2) next_r.beh[15:8] = wb;  // [R1] [R2]
        else if (idx == `LBS_IDX_P1PER) next_r.p1Per = wb;
        else if (idx == `LBS_IDX_P2PER) next_r.p2Per = wb[6:0];
        else if (idx == `LBS_IDX_BRPER) next_r.brPer = wb[6:0];
        else if (idx == `LBS_IDX_CFG) next_r.cfg = wb[6:0];
        else if (idx >= `LBS_IDX_DUTY0 && idx <= `LBS_IDX_DUTY3) next_r.duty[8*(idx[1:0]) +: 8] = wb;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.p1Per <= `LBS_RST_P1PER;
      r.p2Per <= `LBS_RST_P2PER;
      r.brPer <= `LBS_RST_BRPER;
      r.cfg <= `LBS_RST_CFG;
      r.duty <= `LBS_RST_DUTY;
    end
    else
      r <= next_r;
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign cfg.pol = r.pol;
  assign cfg.drv = r.drv;
  assign cfg.link = r.link;
  assign cfg.beh = r.beh;
  assign cfg.p1Per = r.p1Per;
  assign cfg.p2Per = r.p2Per;
  assign cfg.brPer = r.brPer;
  assign cfg.cfg = r.cfg;
  assign cfg.duty = r.duty;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  apbAnswer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not a single cycle");
  behWrite_a: assert property (psel && penable && !pready && pwrite
      && paddr == {2'b00, `LBS_IDX_BEH1, 2'b00} |=> cfg.beh[7:0] == $past(pwdata[7:0])) // [R1]
    else $error("behavior select low not written");
  behHiWrite_a: assert property (psel && penable && !pready && pwrite
      && paddr == {2'b00, `LBS_IDX_BEH2, 2'b00} |=> cfg.beh[15:8] == $past(pwdata[7:0])) // [R2]
    else $error("behavior select high not written");
endmodule : lbs_apb_regs

// File: rtl/lbs_cfg_if.sv
// register values to the sequencer core and channel state back
`timescale 1ns/1ps
interface lbs_cfg_if;
  logic [7:0]  pol;
  logic [7:0]  drv;
  logic [7:0]  link;
  logic [15:0] beh;
  logic [7:0]  p1Per;
  logic [6:0]  p2Per;
  logic [6:0]  brPer;
  logic [6:0]  cfg;
  logic [31:0] duty;
  logic [7:0]  active;
  modport regs (output pol, drv, link, beh, p1Per, p2Per, brPer, cfg, duty, input active);
  modport core (input pol, drv, link, beh, p1Per, p2Per, brPer, cfg, duty, output active);
endinterface : lbs_cfg_if

// File: rtl/lbs_led_sequencer.sv
// eight channel led behavior sequencer with apb register access
`timescale 1ns/1ps
`include "lbs_regs.svh"
// Overview of operation
// R1: two-bit behavior field per led, two registers
// R2: lowest led bits 1:0 upward to 7:6
// R3: linked led starts and stops on triggers
// R4: unlinked led uses drive bit as trigger
// R5: idle pin high if inverted, low otherwise
// R6: unlinked breathing finishes breath before changes
// R7: unlinked pulse 1 ignores bit until done
// R8: link switch follows new source at once
// R9: period change restarts at zero, keeps count
// R10: direct mode follows trigger level
// R11: pulse 1 runs count pulses, no stop
// R12: pulse 2 breathes, then pulses on stop
// R13: breathe ramps min to max, halves
// R14: pwm rate from behavior, period, duty; code runs every channel on one fixed 15-cycle frame
// R15: start edge select picks touch or release
// R16: pulse count field plus one pulses
// R17: pin is pwm combined with polarity
module lbs_led_sequencer
  import lbs_pkg::*;
#(
  parameter int STEP_CYC = `LBS_PER_LSB_NS / `LBS_CLK_NS / `LBS_STEPS
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [7:0]  touchStatus,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  ledPin
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    lbs_chan_t [7:0] ch;
    logic [3:0]      pwmCnt;
    logic [7:0]      pin;
  } lbs_core_t;

  lbs_core_t  s;
  lbs_core_t  next_s;
  lbs_cfg_if  cfg ();
  logic [7:0] trigMon;
  logic [7:0] endMon;

  lbs_apb_regs u_regs (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .cfg     (cfg.regs)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pulse 1, pulse 2 and breathe each keep their own period register; direct takes the breathe one
  function automatic logic [6:0] perOf(input lbs_mode_t m, input logic [7:0] p1, input logic [6:0] p2,
                                       input logic [6:0] br);
    case (m)
      LBS_PULSE1: perOf = p1[6:0];
      LBS_PULSE2: perOf = p2;
      default:    perOf = br;
    endcase
  endfunction : perOf

  // duty byte: pulse1, pulse2, breathe, direct in ascending lanes
  function automatic logic [7:0] dutyOf(input lbs_mode_t m, input logic [31:0] d);
    case (m)
      LBS_PULSE1:  dutyOf = d[7:0];
      LBS_PULSE2:  dutyOf = d[15:8];
      LBS_BREATHE: dutyOf = d[23:16];
      default:     dutyOf = d[31:24];
    endcase
  endfunction : dutyOf

  // linear ramp between the duty limits; a reversed pair holds at min
  function automatic logic [3:0] rampLvl(input logic [3:0] lo, input logic [3:0] hi, input logic [3:0] pos);
    logic [7:0] span;
    span = {4'h0, hi - lo} * {4'h0, pos};
    rampLvl = (hi > lo) ? lo + 4'(span / 8'h0F) : lo;  // [R13]
  endfunction : rampLvl

  // ----------------------------------------------------------------
  // per-channel sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    lbs_chan_t  c;
    lbs_mode_t  selMode;
    logic       trig;
    logic       rise;
    logic       fall;
    logic       linked;
    logic [6:0] per;
    logic [20:0] stepLen;
    logic       stepDone;
    logic       breathEnd;
    logic       running;
    logic [7:0] d;
    logic [3:0] lvl;
    c = '0;
    selMode = LBS_DIRECT;
    trig = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    linked = 1'b0;
    per = 7'h00;
    stepLen = '0;
    stepDone = 1'b0;
    breathEnd = 1'b0;
    running = 1'b0;
    d = 8'h00;
    lvl = 4'h0;
    next_s = s;
    trigMon = '0;
    endMon = '0;
    // one shared frame keeps every channel at the top pwm rate
    next_s.pwmCnt = (s.pwmCnt == `LBS_PWM_LAST) ? 4'h0 : s.pwmCnt + 4'h1;  // [R14]
    for (int i = 0; i < 8; i++)
    begin
      c = s.ch[i];
      linked = cfg.link[i];
      trig = linked ? touchStatus[i] : cfg.drv[i];  // [R3] [R4] [R8]
      trigMon[i] = trig;
      selMode = lbs_mode_t'(cfg.beh[2*i +: 2]);  // [R1] [R2]
      rise = trig & ~c.trigPrev;
      fall = ~trig & c.trigPrev;
      next_s.ch[i].trigPrev = trig;
      per = perOf(c.mode, cfg.p1Per, cfg.p2Per, cfg.brPer);
      stepLen = 21'((per == 7'h00 ? 7'h01 : per) * STEP_CYC);
      stepDone = (c.stepCnt >= stepLen - 21'd1);
      breathEnd = stepDone & c.down & (c.pos == 4'h0);
      endMon[i] = breathEnd;
      running = (c.st != ST_IDLE) && (c.mode != LBS_DIRECT);
      // ramp position: 16 steps up, 16 down, each 1/32 of the period
      if (running)
      begin
        if (stepDone)
        begin
          next_s.ch[i].stepCnt = '0;
          next_s.ch[i].zeroDrive = 1'b0;
          if (!c.down)
          begin
            if (c.pos == `LBS_LVL_TOP) next_s.ch[i].down = 1'b1;  // [R13]
            else next_s.ch[i].pos = c.pos + 4'h1;
          end
          else if (c.pos == 4'h0) next_s.ch[i].down = 1'b0;
          else next_s.ch[i].pos = c.pos - 4'h1;
        end
        else
          next_s.ch[i].stepCnt = c.stepCnt + 21'd1;
      end
      else
      begin
        next_s.ch[i].stepCnt = '0;
        next_s.ch[i].pos = 4'h0;
        next_s.ch[i].down = 1'b0;
        next_s.ch[i].zeroDrive = 1'b0;
      end
      // an unlinked breathing led takes a new mode only between breaths
      if (c.st == ST_IDLE || linked || c.mode == LBS_DIRECT || breathEnd)  // [R6]
        next_s.ch[i].mode = selMode;
      case (c.st)
        ST_IDLE:
        begin
          if (selMode == LBS_PULSE1)
          begin
            if (linked ? (cfg.p1Per[`LBS_TRIG_BIT] ? fall : rise) : rise)  // [R15] [R7]
            begin
              next_s.ch[i].st = ST_PULSE;
              next_s.ch[i].left = cfg.cfg[`LBS_CNT1_LSB +: 3];  // [R16]
            end
          end
          else if (trig)
            next_s.ch[i].st = ST_RUN;  // [R3] [R10]
        end
        ST_RUN:
        begin
          case (c.mode)
            LBS_DIRECT:
              if (!trig) next_s.ch[i].st = ST_IDLE;  // [R10] [R8]
            LBS_BREATHE:
              if (!trig && (linked || breathEnd)) next_s.ch[i].st = ST_IDLE;  // [R3] [R6]
            LBS_PULSE2:
              if (!trig && (linked || breathEnd))
              begin
                next_s.ch[i].st = ST_PULSE;  // [R12]
                next_s.ch[i].left = cfg.cfg[`LBS_CNT2_LSB +: 3];  // [R16]
                next_s.ch[i].pos = 4'h0;
                next_s.ch[i].down = 1'b0;
                next_s.ch[i].stepCnt = '0;
              end
            default:
              next_s.ch[i].st = ST_IDLE;
          endcase
        end
        ST_PULSE:
        begin
          // triggers ignored until the last pulse ends
          if (breathEnd)
          begin
            if (c.left == 3'h0) next_s.ch[i].st = ST_IDLE;  // [R11] [R12] [R7]
            else next_s.ch[i].left = c.left - 3'h1;  // [R16]
          end
        end
        default:
          next_s.ch[i].st = ST_IDLE;
      endcase
      // new period while running: drop to zero drive, keep the count
      next_s.ch[i].lastPer = per;
      if (running && next_s.ch[i].mode == c.mode && per != c.lastPer)
      begin
        next_s.ch[i].stepCnt = '0;  // [R9]
        next_s.ch[i].pos = 4'h0;
        next_s.ch[i].down = 1'b0;
        next_s.ch[i].zeroDrive = 1'b1;
      end
      // envelope level and pwm compare
      d = dutyOf(c.mode, cfg.duty);
      if (c.st == ST_IDLE) lvl = d[3:0];
      else if (c.mode == LBS_DIRECT) lvl = d[7:4];  // [R10] [R14]
      else lvl = rampLvl(d[3:0], d[7:4], c.pos);  // [R11] [R13]
      next_s.ch[i].pwmOn = ~c.zeroDrive & (s.pwmCnt < lvl);  // [R9]
      next_s.pin[i] = cfg.pol[i] ? c.pwmOn : ~c.pwmOn;  // [R5] [R17]
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      s <= '0;
      for (int i = 0; i < 8; i++)
      begin
        s.ch[i].st <= ST_IDLE;
        s.ch[i].mode <= LBS_DIRECT;
      end
      s.pin <= 8'hFF;  // inverted polarity is the reset default
    end
    else
      s <= next_s;
  end

  assign ledPin = s.pin;

  // ----------------------------------------------------------------
  // status and checks per channel
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  for (genvar g = 0; g < 8; g++)
  begin : gChan
    assign cfg.active[g] = (s.ch[g].st != ST_IDLE);

    pinPolarity_a: assert property (##1 ledPin[g] == ($past(cfg.pol[g]) ? $past(s.ch[g].pwmOn)  // [R5]
                                                                          : ~$past(s.ch[g].pwmOn)))
      else $error("led pin not polarity of pwm");
    idleDark_a: assert property (s.ch[g].st == ST_IDLE && dutyOf(s.ch[g].mode, cfg.duty) == 8'hF0  // [R5]
                                 && cfg.pol[g] == 1'b0 ##1 cfg.pol[g] == 1'b0 |=> ledPin[g])
      else $error("idle inverted pin not high");
    directOff_a: assert property (s.ch[g].st == ST_RUN && s.ch[g].mode == LBS_DIRECT && !trigMon[g]  // [R10]
                                  |=> s.ch[g].st == ST_IDLE)
      else $error("direct mode did not release");
    pulseHold_a: assert property (s.ch[g].st == ST_PULSE && !endMon[g]  // [R7]
                                  |=> s.ch[g].st == ST_PULSE && $stable(s.ch[g].left))
      else $error("pulse sequence left early");
    pulseCount_a: assert property (s.ch[g].st == ST_IDLE && next_s.ch[g].st == ST_PULSE  // [R16]
                                   |=> s.ch[g].left == $past(cfg.cfg[`LBS_CNT1_LSB +: 3]))
      else $error("pulse count not loaded");
    breathFinish_a: assert property (s.ch[g].st == ST_RUN && s.ch[g].mode == LBS_BREATHE  // [R6]
                                     && !cfg.link[g] && !endMon[g] |=> s.ch[g].st == ST_RUN)
      else $error("unlinked breath cut short");
    restartZero_a: assert property (s.ch[g].zeroDrive |=> !s.ch[g].pwmOn)  // [R9]
      else $error("restart did not drop drive");
    linkedStop_a: assert property (s.ch[g].st == ST_RUN && s.ch[g].mode == LBS_BREATHE  // [R3]
                                   && cfg.link[g] && !touchStatus[g] |=> s.ch[g].st == ST_IDLE)
      else $error("linked breathe ignored release");
  end

  pulse2Cov_c: cover property (s.ch[0].st == ST_RUN && s.ch[0].mode == LBS_PULSE2 ##1 s.ch[0].st == ST_PULSE);
  pulse1Cov_c: cover property (s.ch[0].st == ST_PULSE && s.ch[0].mode == LBS_PULSE1 ##1 s.ch[0].st == ST_IDLE);
  breatheCov_c: cover property (s.ch[0].mode == LBS_BREATHE && endMon[0]);
  restartCov_c: cover property (s.ch[0].zeroDrive);
endmodule : lbs_led_sequencer

// File: rtl/lbs_pkg.sv
// types shared by the led sequencer modules
package lbs_pkg;
  typedef enum logic [1:0] {
    LBS_DIRECT  = 2'b00,
    LBS_PULSE1  = 2'b01,
    LBS_PULSE2  = 2'b10,
    LBS_BREATHE = 2'b11
  } lbs_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_PULSE = 3'b100
  } lbs_state_t;
  typedef struct packed {
    lbs_state_t  st;
    logic        trigPrev;
    lbs_mode_t   mode;
    logic [3:0]  pos;
    logic        down;
    logic [20:0] stepCnt;
    logic [2:0]  left;
    logic        zeroDrive;
    logic [6:0]  lastPer;
    logic        pwmOn;
  } lbs_chan_t;
  typedef struct packed {
    logic [7:0]  pol;
    logic [7:0]  drv;
    logic [7:0]  link;
    logic [15:0] beh;
    logic [7:0]  p1Per;
    logic [6:0]  p2Per;
    logic [6:0]  brPer;
    logic [6:0]  cfg;
    logic [31:0] duty;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lbs_reg_t;
endpackage : lbs_pkg

// File: rtl/lbs_regs.svh
// register indices, reset values, field positions and timing constants
`ifndef LBS_REGS_SVH
`define LBS_REGS_SVH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LBS_IDX_STAT  8'h60
`define LBS_IDX_POL   8'h73
`define LBS_IDX_DRV   8'h74
`define LBS_IDX_LINK  8'h75
`define LBS_IDX_BEH1  8'h81
`define LBS_IDX_BEH2  8'h82
`define LBS_IDX_P1PER 8'h84
`define LBS_IDX_P2PER 8'h85
`define LBS_IDX_BRPER 8'h86
`define LBS_IDX_CFG   8'h88
`define LBS_IDX_DUTY0 8'h90
`define LBS_IDX_DUTY3 8'h93
`define LBS_IDX_HI    9
`define LBS_IDX_LO    2
`define LBS_ADDR_TOP  11
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LBS_RST_ZERO  8'h00
`define LBS_RST_P1PER 8'h20
`define LBS_RST_P2PER 7'h14
`define LBS_RST_BRPER 7'h5D
`define LBS_RST_CFG   7'h04
`define LBS_RST_DUTY  32'hF0F0_F0F0
// ----------------------------------------------------------------
// fields and timing
// ----------------------------------------------------------------
`define LBS_TRIG_BIT  7
`define LBS_CNT1_LSB  0
`define LBS_CNT2_LSB  3
`define LBS_PER_LSB_NS 32000000
`define LBS_CLK_NS    100
`define LBS_STEPS     32
`define LBS_LVL_TOP   4'hF
`define LBS_PWM_LAST  4'hE
`endif

// File: sim/lbs_led_model.sv
// touch detect source and led observer on the pin side of the sequencer
`timescale 1ns/1ps
module lbs_led_model
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] touchCmd,
  input  wire logic [2:0] watchChan,
  input  wire logic       clrCnt,
  input  wire logic [7:0] ledPin,
  output logic      [7:0] touchStatus = 8'h00,
  output int              litCnt
);
  // --------------------------------------------------------------
  // touch level and lit-time counter
  // --------------------------------------------------------------
  // touch logic shares the clock, so its level changes only at edges
  always @(posedge sys_clk)
  begin
    touchStatus <= touchCmd;
    // pin sinks led current: a low pin is a lit led
    litCnt <= clrCnt ? 0 : litCnt + int'(ledPin[watchChan] === 1'b0);
  end
endmodule : lbs_led_model

// File: sim/tb_lbs_led_sequencer.sv
// self-checking bench for the eight channel led sequencer
`timescale 1ns/1ps
`include "lbs_regs.svh"
module tb_lbs_led_sequencer;
  logic        sys_clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  ledPin;
  logic [7:0]  touchStatus;
  logic [7:0]  touchCmd;
  logic [2:0]  watchChan;
  logic        clrCnt;
  logic [31:0] rdat;
  logic        rerr;
  int          litCnt;
  int          cyc;
  int          n;
  int          miscompares;
  int          samples_checked;
  // short step keeps a breath at 64 cycles per period unit
  lbs_led_sequencer #(.STEP_CYC(2)) i_dut (.*);
  lbs_led_model i_led (.*);
  // --------------------------------------------------------------
  // clock, cycle count and tasks
  // --------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkr(input string nm, input int lo, input int hi, input int g);
    chk(nm, 32'h0000_0001, 32'(lo <= g && g <= hi));
  endtask : chkr
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : tick
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (k >= 50)
    begin
      miscompares++;
      $display("MISMATCH pready expected 1 seen 0");
      wrap_up();
    end
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h00_0000, d});
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input string nm);
    apb(1'b0, idx, 32'h0000_0000);
    chk(nm, e, rdat);
  endtask : rd
  // polls one status bit; a bound that runs out ends the run
  task automatic wst(input int ch, input int lim, output int m);
    int t0;
    t0 = cyc;
    do apb(1'b0, `LBS_IDX_STAT, 32'h0000_0000); while (rdat[ch] !== 1'b0 && cyc - t0 < lim);
    m = cyc - t0;
    chk("status clear", 32'h0000_0000, 32'(rdat[ch]));
    if (rdat[ch] !== 1'b0)
      wrap_up();
  endtask : wst
  task automatic clr();
    clrCnt <= 1'b1;
    tick(1);
    clrCnt <= 1'b0;
  endtask : clr
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    touchCmd = 8'h00; watchChan = 3'h3; clrCnt = 1'b0;
    tick(10);
    rst_b <= 1'b1;
    tick(1);
    chk("idle pins", 32'h0000_00FF, 32'(ledPin));
    rd(`LBS_IDX_BEH1, 32'h0000_0000, "mode low");
    rd(`LBS_IDX_BEH2, 32'h0000_0000, "mode high");
    rd(`LBS_IDX_P1PER, 32'h0000_0020, "pulse1 period");
    rd(`LBS_IDX_CFG, 32'h0000_0004, "pulse counts");
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'(rerr));
    wr(`LBS_IDX_POL, 8'h0F);
    tick(3);
    chk("non-inverted idle", 32'h0000_00F0, 32'(ledPin));
    wr(`LBS_IDX_POL, 8'h00);
    wr(`LBS_IDX_BRPER, 8'h01);
    wr(`LBS_IDX_BEH1, 8'hC0);
    rd(`LBS_IDX_BEH1, 32'h0000_00C0, "mode low");
    wr(`LBS_IDX_DRV, 8'h01);
    tick(3);
    chk("direct on", 32'h0000_0000, 32'(ledPin[0]));
    wr(`LBS_IDX_POL, 8'h01);
    tick(3);
    chk("direct polarity", 32'h0000_0001, 32'(ledPin[0]));
    wr(`LBS_IDX_POL, 8'h00);
    wr(`LBS_IDX_DRV, 8'h00);
    tick(3);
    chk("direct off", 32'h0000_0001, 32'(ledPin[0]));
    wr(`LBS_IDX_LINK, 8'h02);
    // touch level, state, pwm and pin each take one edge
    touchCmd <= 8'h02;
    tick(5);
    chk("linked touch", 32'h0000_0000, 32'(ledPin[1]));
    touchCmd <= 8'h00;
    tick(5);
    chk("linked release", 32'h0000_0001, 32'(ledPin[1]));
    wr(`LBS_IDX_DRV, 8'h04);
    tick(3);
    chk("drive on", 32'h0000_0000, 32'(ledPin[2]));
    wr(`LBS_IDX_LINK, 8'h06);
    tick(3);
    chk("relinked release", 32'h0000_0001, 32'(ledPin[2]));
    wr(`LBS_IDX_LINK, 8'h00);
    // breathe in the top field of the low register drives the fourth pin
    wr(`LBS_IDX_DRV, 8'h08);
    clr();
    tick(64);
    chkr("breath lit cycles", 8, 56, litCnt);
    wr(`LBS_IDX_DRV, 8'h00);
    rd(`LBS_IDX_STAT, 32'h0000_0008, "breath kept");
    wst(3, 300, n);
    chkr("breath finish", 20, 70, n);
    wr(`LBS_IDX_BRPER, 8'h04);
    wr(`LBS_IDX_DRV, 8'h08);
    tick(100);
    wr(`LBS_IDX_BRPER, 8'h05);
    clr();
    tick(5);
    chk("period restart", 32'h0000_0000, 32'(litCnt));
    wr(`LBS_IDX_DRV, 8'h00);
    wst(3, 800, n);
    wr(`LBS_IDX_BEH2, 8'h04);
    wr(`LBS_IDX_CFG, 8'h01);
    wr(`LBS_IDX_P1PER, 8'h01);
    wr(`LBS_IDX_DRV, 8'h20);
    wr(`LBS_IDX_DRV, 8'h00);
    wr(`LBS_IDX_DRV, 8'h20);
    wst(5, 300, n);
    chkr("pulse1 length", 96, 136, n);
    tick(10);
    rd(`LBS_IDX_STAT, 32'h0000_0000, "no retrigger");
    wr(`LBS_IDX_DRV, 8'h00);
    wr(`LBS_IDX_P2PER, 8'h01);
    wr(`LBS_IDX_BEH2, 8'h20);
    wr(`LBS_IDX_LINK, 8'h40);
    touchCmd <= 8'h40;
    tick(100);
    rd(`LBS_IDX_STAT, 32'h0000_0040, "pulse2 breathing");
    touchCmd <= 8'h00;
    wst(6, 300, n);
    chkr("pulse2 tail", 48, 84, n);
    wr(`LBS_IDX_BEH2, 8'h40);
    wr(`LBS_IDX_LINK, 8'h80);
    touchCmd <= 8'h80;
    tick(6);
    rd(`LBS_IDX_STAT, 32'h0000_0080, "start on touch");
    touchCmd <= 8'h00;
    wst(7, 300, n);
    chkr("pulse1 no stop", 100, 140, n);
    wr(`LBS_IDX_P1PER, 8'h81);
    touchCmd <= 8'h80;
    tick(10);
    rd(`LBS_IDX_STAT, 32'h0000_0000, "wait release");
    touchCmd <= 8'h00;
    tick(6);
    rd(`LBS_IDX_STAT, 32'h0000_0080, "start on release");
    // linked breathe stops at once on release, pulse keeps going
    wr(`LBS_IDX_LINK, 8'h88);
    touchCmd <= 8'h08;
    tick(20);
    rd(`LBS_IDX_STAT, 32'h0000_0088, "linked breathe");
    touchCmd <= 8'h00;
    tick(3);
    rd(`LBS_IDX_STAT, 32'h0000_0080, "linked breathe stop");
    wrap_up();
  end
  // hang guard
  initial
  begin
    tick(60000);
    miscompares++;
    wrap_up();
  end
endmodule : tb_lbs_led_sequencer
